// ==== flash_info_area_sequencer.sv ====
`timescale 1ns/100ps
`include "flash_info_defs.svh"
module flash_info_area_sequencer
   import flash_info_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Flash read port
   input wire logic flashReqValid,
   input wire flashReq_t flashReq,
   input wire logic [31:0] planeData,
   output logic [31:0] flashRdata,
   output logic flashRvalid,
   output logic flashDenied,
   // Page buffer, signature programming source
   output logic [6:0] pageIdx,
   input wire logic [31:0] pageData,
   // Wipe pin and nonvolatile bits
   input wire logic wipeRequest,
   input wire logic securityNvInit,
   input wire logic verifyFail,
   // Ready interrupt, and mode outputs to fetch logic
   output logic readyIrq,
   output logic seqOptDisable,
   output logic readWidthSelect,
   output logic loopOptEnable
);

   // ****************************************
   // Identifier storage
   // ****************************************
   // Factory id is a constant table; value here is arbitrary
   logic [31:0] uidRom [0:`UID_WORDS-1];
   genvar gi;
   generate
      for (gi = 0; gi < `UID_WORDS; gi++) begin : g_uid
         assign uidRom[gi] = {24'hC0FFEE, 8'(gi)};
      end
   endgenerate

   state_t cur;
   state_t next_s;
   logic secureLoaded;

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      logic wr;
      logic rd;
      logic [7:0] op;
      logic hit;
      logic addrUid;
      logic addrSig;
      wr = psel && penable && pwrite && !cur.pready;
      rd = psel && penable && !pwrite && !cur.pready;
      op = pwdata[7:0];
      hit = 1'b0;
      addrUid = 1'b0;
      addrSig = 1'b0;
      next_s = cur;
      next_s.pready = psel && penable && !cur.pready;
      next_s.rvalid = 1'b0;
      next_s.denied = 1'b0;
      next_s.irq = 1'b0;
      // Register reads; status read clears command error
      if (rd) begin
         if (paddr == `OFS_MODE) begin
            next_s.prdata = cur.mode;
         end else if (paddr == `OFS_STATUS) begin
            next_s.prdata = 32'h0;
            next_s.prdata[`ST_READY] = cur.ready;
            next_s.prdata[`ST_CMDERR] = cur.cmdErr;
            next_s.prdata[`ST_VERIFY] = cur.verifyErr;
            next_s.cmdErr = 1'b0;
         end else if (paddr == `OFS_SECURITY) begin
            next_s.prdata = {31'h0, cur.secure};
         end else begin
            next_s.prdata = 32'h0;
         end
      end
      if (wr && paddr == `OFS_MODE) begin
         next_s.mode = pwdata & `MODE_WRITE_MASK;
      end
      // Command register write
      if (wr && paddr == `OFS_COMMAND) begin
         next_s.cmdErr = 1'b0;
         // Busy means a timed program or erase runs; read modes still take their end command
         if (pwdata[31:24] != `CMD_KEY || cur.state != IDLE) begin
            next_s.cmdErr = 1'b1;
         end else if (op == `OP_BEGIN_UID) begin
            next_s.uidMode = 1'b1;
            next_s.ready = 1'b0;
         end else if (op == `OP_END_UID) begin
            next_s.uidMode = 1'b0;
            next_s.ready = 1'b1;
            next_s.irq = cur.mode[`MODE_READY_IE];
         end else if (op == `OP_BEGIN_SIG) begin
            next_s.sigMode = 1'b1;
            next_s.ready = 1'b0;
         end else if (op == `OP_END_SIG) begin
            next_s.sigMode = 1'b0;
            next_s.ready = 1'b1;
            next_s.irq = cur.mode[`MODE_READY_IE];
         end else if (op == `OP_PROG_SIG) begin
            next_s.state = PROGRAM;
            next_s.timer = `PROG_CYCLES;
            next_s.progIdx = 7'h0;
            next_s.ready = 1'b0;
            next_s.verifyErr = 1'b0;
         end else if (op == `OP_CLEAR_SIG) begin
            next_s.state = ERASE;
            next_s.timer = `ERASE_CYCLES;
            next_s.ready = 1'b0;
            next_s.verifyErr = 1'b0;
         end else begin
            next_s.cmdErr = 1'b1;
         end
      end
      // Program and erase sequencer
      case (cur.state)
         IDLE: begin
            if (wipeRequest && !cur.wipeSeen) begin
               next_s.wipeSeen = 1'b1;
               next_s.state = CHIP_ERASE;
               next_s.timer = `CHIP_ERASE_CYCLES;
               next_s.ready = 1'b0;
            end
         end
         PROGRAM: begin
            next_s.sig[cur.progIdx] = pageData;
            next_s.progIdx = cur.progIdx + 7'd1;
            next_s.timer = cur.timer - 8'd1;
            if (cur.timer == 8'd1) begin
               next_s.state = IDLE;
               next_s.ready = 1'b1;
               next_s.verifyErr = verifyFail;
               next_s.irq = cur.mode[`MODE_READY_IE];
            end
         end
         ERASE: begin
            if (cur.timer[6:0] != 7'h0) begin
               next_s.sig[cur.timer[6:0]] = 32'hFFFFFFFF;
            end else begin
               next_s.sig[0] = 32'hFFFFFFFF;
            end
            next_s.timer = cur.timer - 8'd1;
            if (cur.timer == 8'd1) begin
               next_s.state = IDLE;
               next_s.ready = 1'b1;
               next_s.verifyErr = verifyFail;
               next_s.irq = cur.mode[`MODE_READY_IE];
            end
         end
         CHIP_ERASE: begin
            next_s.timer = cur.timer - 8'd1;
            if (cur.timer == 8'd1) begin
               next_s.state = IDLE;
               next_s.ready = 1'b1;
               next_s.secure = 1'b0;
               next_s.irq = cur.mode[`MODE_READY_IE];
            end
         end
         default: begin
            next_s.state = IDLE;
         end
      endcase
      if (!wipeRequest) begin
         next_s.wipeSeen = 1'b0;
      end
      // Nonvolatile bit zero image loaded once after reset
      if (!secureLoaded) begin
         next_s.secure = securityNvInit;
      end
      // Flash read path with wait states
      if (cur.busy) begin
         next_s.waitCnt = cur.waitCnt - 4'd1;
         if (cur.waitCnt == 4'd0) begin
            next_s.busy = 1'b0;
            next_s.rvalid = 1'b1;
            addrUid = cur.uidMode && flashReq.addr >= `INFO_BASE && flashReq.addr <= `UID_LAST;
            addrSig = cur.sigMode && flashReq.addr >= `INFO_BASE && flashReq.addr <= `SIG_LAST;
            if (addrUid) begin
               next_s.rdata = uidRom[flashReq.addr[9:2]];
            end else if (addrSig) begin
               next_s.rdata = cur.sig[flashReq.addr[8:2]];
            end else begin
               next_s.rdata = planeData;
            end
         end
      end else if (flashReqValid && !cur.rvalid && !cur.denied) begin
         // Requester still holds the old request during the answer cycle; do not take it twice
         hit = cur.secure && flashReq.fromDebug;
         if (hit) begin
            next_s.denied = 1'b1;
            next_s.rdata = 32'h0;
         end else begin
            next_s.busy = 1'b1;
            next_s.waitCnt = cur.mode[`MODE_WAIT_LSB +: 4];
         end
      end
   end

   // ****************************************
   // State register
   // ****************************************
   always_ff @(posedge clk) begin
      if (!nrst) begin
         cur <= '0;
         cur.state <= IDLE;
         cur.mode <= `RESET_MODE;
         cur.ready <= 1'(`RESET_STATUS);
         secureLoaded <= 1'b0;
      end else begin
         cur <= next_s;
         secureLoaded <= 1'b1;
      end
   end

   // Outputs straight from the state flops, except pslverr which is tied low
   assign prdata = cur.prdata;
   assign pready = cur.pready;
   assign pslverr = 1'b0;
   assign flashRdata = cur.rdata;
   assign flashRvalid = cur.rvalid;
   assign flashDenied = cur.denied;
   assign pageIdx = cur.progIdx;
   assign readyIrq = cur.irq;
   assign seqOptDisable = cur.mode[`MODE_SEQ_DIS];
   assign readWidthSelect = cur.mode[`MODE_WIDTH];
   assign loopOptEnable = cur.mode[`MODE_LOOP];

endmodule // flash_info_area_sequencer

// ==== flash_info_area_sequencer_test.sv ====
`timescale 1ns/100ps
`include "flash_info_defs.svh"
module flash_info_area_sequencer_test import flash_info_pkg::*; ;
   logic clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, flashReqValid = 1'b0;
   logic wipeRequest = 1'b0, securityNvInit = 1'b1, verifyFail = 1'b0, irqSeen = 1'b0, den;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000, planeData = 32'h13572468, prdata, flashRdata, pageData, rd;
   logic pready, pslverr, flashRvalid, flashDenied, readyIrq, seqOptDisable, readWidthSelect, loopOptEnable;
   logic [6:0] pageIdx;
   flashReq_t flashReq = '0;
   int errors = 0, compares = 0, cycles = 0;
   assign pageData = {16'hA5A5, 9'h000, pageIdx};
   flash_info_area_sequencer u_flash_info_area_sequencer (.clk, .nrst, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .flashReqValid, .flashReq, .planeData, .flashRdata, .flashRvalid,
      .flashDenied, .pageIdx, .pageData, .wipeRequest, .securityNvInit, .verifyFail, .readyIrq,
      .seqOptDisable, .readWidthSelect, .loopOptEnable);
   // ****
   // Bench tasks
   // ****
   initial forever #2 clk = ~clk;
   // Interrupt catcher and hang limit
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (readyIrq === 1'b1) irqSeen <= 1'b1;
      if (cycles == 20000) begin
         errors = errors + 1;
         finish_test();
      end
   end
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   // An idle edge first, so release and next request never share a time step
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge clk) penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata; psel <= 1'b0; penable <= 1'b0;
   endtask
   task automatic cmd(input logic [7:0] key, input logic [7:0] code);
      apb(1'b1, `OFS_COMMAND, {key, 16'hBEEF, code});
   endtask
   task automatic status(input string what, input logic [31:0] exp);
      apb(1'b0, `OFS_STATUS, 32'h0);
      chk(what, exp, rd);
   endtask
   task automatic waitReady();
      do apb(1'b0, `OFS_STATUS, 32'h0); while (rd[0] !== 1'b1);
   endtask
   task automatic fread(input logic [31:0] a, input logic dbg);
      @(posedge clk);
      flashReq <= '{addr: a, read: 1'b1, fromDebug: dbg};
      flashReqValid <= 1'b1;
      do @(posedge clk); while (flashRvalid !== 1'b1 && flashDenied !== 1'b1);
      rd = flashRdata; den = flashDenied; flashReqValid <= 1'b0;
   endtask
   task automatic finish_test();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // ****
   // Scenarios
   // ****
   task automatic t_regs();
      apb(1'b0, `OFS_MODE, 32'h0); chk("mode", `RESET_MODE, rd);
      status("status", `RESET_STATUS);
      apb(1'b0, 12'h020, 32'h0); chk("unmapped", 32'h0, rd);
      apb(1'b0, `OFS_RESULT, 32'h0); chk("result", 32'h0, rd);
      apb(1'b1, `OFS_MODE, 32'h05010F01); @(posedge clk); // no flash read around mode changes
      chk("pins", 32'h7, {29'h0, loopOptEnable, readWidthSelect, seqOptDisable});
      apb(1'b1, `OFS_MODE, 32'h00000001); @(posedge clk);
      chk("pins", 32'h0, {29'h0, loopOptEnable, readWidthSelect, seqOptDisable});
      apb(1'b1, `OFS_STATUS, 32'h0); status("status ro", 32'h1);
   endtask
   task automatic t_key();
      cmd(8'hA5, `OP_BEGIN_UID); status("bad key", 32'h3);
      status("err clear", 32'h1);
      cmd(`CMD_KEY, 8'h30); status("bad code", 32'h3);
   endtask
   task automatic t_uid();
      irqSeen <= 1'b0;
      cmd(`CMD_KEY, `OP_BEGIN_UID); status("uid busy", 32'h0); // only data reads follow
      fread(32'h00400004, 1'b0); chk("uid", 32'hC0FFEE01, rd);
      fread(`UID_LAST - 32'h3, 1'b0); chk("uid top", 32'hC0FFEEFF, rd);
      cmd(`CMD_KEY, `OP_END_UID); status("uid end", 32'h1);
      chk("irq", 32'h1, {31'h0, irqSeen});
   endtask
   task automatic t_sig();
      apb(1'b1, `OFS_MODE, 32'h00000200);
      irqSeen <= 1'b0;
      verifyFail <= 1'b1;
      cmd(`CMD_KEY, `OP_CLEAR_SIG); waitReady(); chk("erase err", 32'h9, rd);
      verifyFail <= 1'b0;
      cmd(`CMD_KEY, `OP_PROG_SIG); waitReady(); chk("prog", 32'h1, rd);
      chk("irq off", 32'h0, {31'h0, irqSeen});
      cmd(`CMD_KEY, `OP_BEGIN_SIG); status("sig busy", 32'h0); // no fetch meanwhile
      fread(32'h00400014, 1'b0); chk("sig", 32'hA5A50005, rd);
      fread(32'h00400100, 1'b0); chk("sig erased", 32'hFFFFFFFF, rd);
      cmd(`CMD_KEY, `OP_END_SIG); status("sig end", 32'h1);
      fread(32'h00400014, 1'b0); chk("plane", planeData, rd);
   endtask
   task automatic t_secure();
      fread(32'h00000100, 1'b1); chk("denied", 32'h1, {31'h0, den});
      wipeRequest <= 1'b1;
      repeat (300) @(posedge clk);
      wipeRequest <= 1'b0;
      fread(32'h00000100, 1'b1); chk("open", {31'h0, 1'b0}, {31'h0, den});
      chk("open data", planeData, rd);
   endtask
   // Main sequence
   initial begin
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      repeat (2) @(posedge clk);
      t_regs();
      t_key();
      t_uid();
      t_sig();
      t_secure();
      finish_test();
   end
endmodule // flash_info_area_sequencer_test

// ==== flash_info_asserts.sv ====
`timescale 1ns/100ps
`include "flash_info_defs.svh"
module flash_info_asserts
   import flash_info_pkg::*;
(
   // Clock, reset and APB
   input wire logic clk, nrst, psel, penable, pwrite, pready,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata, prdata,
   // Flash port, ready interrupt and mode outputs
   input wire logic flashReqValid, flashRvalid, flashDenied, readyIrq,
   input wire flashReq_t flashReq,
   input wire logic seqOptDisable, readWidthSelect, loopOptEnable
);
   logic [3:0] ws;
   logic ie;
   logic [4:0] waitCyc;
   wire logic modeWr = psel && penable && pready && pwrite && paddr == `OFS_MODE;
   // Shadow of mode fields, so latency checks follow software changes
   always_ff @(posedge clk) begin
      if (!nrst) begin
         ws <= 4'h0;
         ie <= 1'b0;
         waitCyc <= 5'h00;
      end else begin
         if (modeWr) begin
            ws <= pwdata[11:8];
            ie <= pwdata[0];
         end
         waitCyc <= (flashReqValid && !flashRvalid && !flashDenied) ? waitCyc + 5'h01 : 5'h00;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   AST_APB_ANSWER: assert property (psel && penable && !pready |=> pready ##1 !pready)
      else $error("pready is not a single answer cycle");
   AST_RESULT_ZERO: assert property (psel && penable && pready && !pwrite && paddr == `OFS_RESULT |-> !prdata)
      else $error("result register read not zero");
   AST_SEQ_BIT: assert property (modeWr |=> seqOptDisable == $past(pwdata[16]))
      else $error("sequential disable output wrong");
   AST_WIDTH_BIT: assert property (modeWr |=> readWidthSelect == $past(pwdata[24]))
      else $error("read width output wrong");
   AST_LOOP_BIT: assert property (modeWr |=> loopOptEnable == $past(pwdata[26]))
      else $error("loop optimisation output wrong");
   AST_WAIT_STATES: assert property (flashRvalid |-> waitCyc == {1'b0, ws} + 5'h02)
      else $error("flash read latency wrong");
   AST_DENY_DEBUG: assert property (flashDenied |-> flashReqValid && flashReq.fromDebug && !flashRvalid)
      else $error("denial of a non-debug access");
   AST_IRQ_ENABLE: assert property (readyIrq |-> ie)
      else $error("ready interrupt while disabled");
endmodule // flash_info_asserts
bind flash_info_area_sequencer flash_info_asserts u_flash_info_asserts (.clk, .nrst, .psel, .penable, .pwrite,
   .pready, .paddr, .pwdata, .prdata, .flashReqValid, .flashRvalid, .flashDenied, .readyIrq, .flashReq,
   .seqOptDisable, .readWidthSelect, .loopOptEnable);

// ==== flash_info_defs.svh ====
`ifndef FLASH_INFO_DEFS_SVH
`define FLASH_INFO_DEFS_SVH

// ****************************************
// Register map
// ****************************************
`define OFS_MODE 12'h000
`define OFS_COMMAND 12'h004
`define OFS_STATUS 12'h008
`define OFS_RESULT 12'h00C
`define OFS_SECURITY 12'h010
`define RESET_MODE 32'h04000000
`define RESET_STATUS 32'h00000001

// ****************************************
// Fields
// ****************************************
`define MODE_WRITE_MASK 32'h05010F01
`define MODE_READY_IE 0
`define MODE_WAIT_LSB 8
`define MODE_SEQ_DIS 16
`define MODE_WIDTH 24
`define MODE_LOOP 26
`define ST_READY 0
`define ST_CMDERR 1
`define ST_VERIFY 3
`define CMD_KEY 8'h5A
`define OP_BEGIN_UID 8'h0E
`define OP_END_UID 8'h0F
`define OP_PROG_SIG 8'h12
`define OP_CLEAR_SIG 8'h13
`define OP_BEGIN_SIG 8'h14
`define OP_END_SIG 8'h15

// ****************************************
// Geometry and timing
// ****************************************
`define UID_WORDS 256
`define SIG_WORDS 128
`define INFO_BASE 32'h00400000
`define UID_LAST 32'h004003FF
`define SIG_LAST 32'h004001FF
`define PROG_CYCLES 8'd64
`define ERASE_CYCLES 8'd128
`define CHIP_ERASE_CYCLES 8'd255

`endif

// ==== flash_info_pkg.sv ====
package flash_info_pkg;
   typedef enum logic [2:0] {IDLE, PROGRAM, ERASE, CHIP_ERASE} seqState_t;
   typedef struct packed {
      logic [31:0] addr;
      logic read;
      logic fromDebug;
   } flashReq_t;
   typedef struct packed {
      seqState_t state;
      logic [7:0] timer;
      logic [31:0] mode;
      logic ready;
      logic cmdErr;
      logic verifyErr;
      logic uidMode;
      logic sigMode;
      logic secure;
      logic wipeSeen;
      logic irq;
      logic [31:0] prdata;
      logic pready;
      logic [3:0] waitCnt;
      logic busy;
      logic [31:0] rdata;
      logic rvalid;
      logic denied;
      logic [6:0] progIdx;
      logic [127:0][31:0] sig;
   } state_t;
endpackage
